// ===== src/lcdmc_top.sv
// Purpose: Display mode control: decodes instructions, holds mode bits,
//          address counter, display shift, blink and frame timing.
// Assumes: Host port is synchronous to CLOCK; EXPANDER pin is not.
// Notes:   RAM data transfers and scroll quantity are handled elsewhere.
//
// The implementer's own choices: strobed register access and the placing of the registers.
module lcdmc_top #(
	parameter int BLINK_TICKS = lcdmc_pkg::BLINK_OSC
) (
	input  wire logic               CLOCK,
	input  wire logic               RST,
	input  wire logic               ADDR,
	input  wire logic [7:0]         WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic      [7:0]         RDATA,
	input  wire logic               EXPANDER_PRESENT,
	output logic                    DISPLAY_ON,
	output logic                    CURSOR_SHOW,
	output logic                    CURSOR_BLANK,
	output logic                    CURSOR_INVERT,
	output logic                    USER_BLINK_PHASE,
	output logic      [2:0]         CELL_DOTS,
	output logic                    ROM_LEFT_BLANK,
	output logic                    FRAME_TICK,
	output logic                    CORE_TICK,
	output lcdmc_pkg::lcdmc_lines_t LINE_MODE,
	output logic      [6:0]         ADDR_COUNTER,
	output logic      [6:0]         SHIFT_OFFSET,
	output logic      [3:0]         LINE_SCROLL_EN,
	output lcdmc_pkg::lcdmc_ram_t   RAM_SEL,
	output logic      [1:0]         ICON_ADDR_HIGH_SEL,
	output logic                    BUS_WIDTH_SEL,
	output logic                    EXT_REG_ENABLE,
	output logic                    LOW_POWER_ACTIVE
);
	import lcdmc_pkg::*;
	function automatic logic [6:0] next_addr(
		input logic [6:0]   a,
		input logic         right,
		input lcdmc_lines_t lm
	);
		logic [6:0] r;
		r = right ? 7'(a + 7'h01) : 7'(a - 7'h01);
		case (lm)
			LINES_TWO: begin
				if (right && a == AC_TWO_END1) begin
					r = AC_TWO_BEG2;
				end else if (right && a == AC_TWO_END2) begin
					r = 7'h00;
				end else if (!right && a == 7'h00) begin
					r = AC_TWO_END2;
				end else if (!right && a == AC_TWO_BEG2) begin
					r = AC_TWO_END1;
				end
			end
			LINES_FOUR: begin
				if (right && a[4:0] == AC_FOUR_END) begin
					r = {2'(a[6:5] + 2'h1), 5'h00};
				end else if (!right && a[4:0] == 5'h00) begin
					r = {2'(a[6:5] - 2'h1), AC_FOUR_END};
				end
			end
			default: begin
				if (right && a == AC_ONE_LAST) begin
					r = 7'h00;
				end else if (!right && a == 7'h00) begin
					r = AC_ONE_LAST;
				end
			end
		endcase
		return r;
	endfunction : next_addr
	function automatic logic [6:0] line_len(input lcdmc_lines_t lm);
		case (lm)
			LINES_TWO:  return LEN_TWO;
			LINES_FOUR: return LEN_FOUR;
			default:    return LEN_ONE;
		endcase
	endfunction : line_len
	// Mode state
	logic         disp_on_q;
	logic         cursor_q;
	logic         char_blink_q;
	logic         font_width_sel_q;
	logic         invert_cursor_q;
	logic         four_line_sel_q;
	logic         two_line_sel_q;
	logic         bus_width_sel_q;
	logic         ext_reg_enable_q;
	logic         user_font_blink_en_q;
	logic         low_power_sel_q;
	logic [3:0]   line_scroll_enable_q;
	logic [1:0]   icon_addr_high_sel_q;
	logic [6:0]   addr_counter_q;
	logic [6:0]   shift_q;
	lcdmc_ram_t   ram_sel_q;
	// Host port
	lcdmc_nib_t   nib_q;
	logic [3:0]   nib_hold_q;
	logic [7:0]   rdata_q;
	// Timing
	logic [6:0]   osc_cnt_q;
	logic         osc_tick;
	logic [1:0]   div_cnt_q;
	logic         core_tick_q;
	logic [16:0]  blink_cnt_q;
	logic         blink_phase_q;
	logic [8:0]   frame_cnt_q;
	logic         frame_tick_q;
	logic         ext_s1_q;
	logic         ext_s2_q;
	// Decode
	logic         wr_byte;
	logic [7:0]   ins;
	logic         rd_byte;
	lcdmc_lines_t lines_d;
	logic         lp_active;
	logic [7:0]   rd_full;
	// Expander strap pin synchroniser
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ext_s1_q <= 1'h0;
			ext_s2_q <= 1'h0;
		end else begin
			ext_s1_q <= EXPANDER_PRESENT;
			ext_s2_q <= ext_s1_q;
		end
	end
	// Byte assembly: 8-bit, or two nibbles on the upper lanes
	always_comb begin
		wr_byte = 1'b0;
		rd_byte = 1'b0;
		ins     = WDATA;
		if (bus_width_sel_q) begin
			wr_byte = WR && ADDR == ADDR_INSTR;
			rd_byte = RD;
		end else begin
			wr_byte = WR && ADDR == ADDR_INSTR && nib_q == NIB_LOW;
			rd_byte = RD && nib_q == NIB_LOW;
			ins     = {nib_hold_q, WDATA[7:4]};
		end
	end
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			nib_q      <= NIB_HIGH;
			nib_hold_q <= 4'h0;
		end else if (!bus_width_sel_q && (WR || RD)) begin
			nib_q <= (nib_q == NIB_HIGH) ? NIB_LOW : NIB_HIGH;
			if (WR && nib_q == NIB_HIGH) begin
				nib_hold_q <= WDATA[7:4];
			end
		end else if (bus_width_sel_q) begin
			nib_q <= NIB_HIGH;
		end
	end
	// Line format: four-line select wins over two-line select
	always_comb begin
		if (four_line_sel_q) begin
			lines_d = LINES_FOUR;
		end else if (two_line_sel_q) begin
			lines_d = LINES_TWO;
		end else begin
			lines_d = LINES_ONE;
		end
	end
	assign lp_active = low_power_sel_q && !ext_s2_q;
	// Display on/off control and extension function set
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			disp_on_q        <= 1'h0;
			cursor_q         <= 1'h0;
			char_blink_q     <= 1'h0;
			font_width_sel_q <= 1'h0;
			invert_cursor_q  <= 1'h0;
			four_line_sel_q  <= 1'h0;
		end else if (wr_byte && ins[7:4] == 4'h0 && ins[3]) begin
			if (!ext_reg_enable_q) begin
				disp_on_q    <= ins[2];
				cursor_q     <= ins[1];
				char_blink_q <= ins[0];
			end else begin
				font_width_sel_q <= ins[B_FW];
				invert_cursor_q  <= ins[B_BW];
				four_line_sel_q  <= ins[B_NW];
			end
		end
	end
	// Function set; the shift instruction leaves ext_reg_enable unchanged
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			bus_width_sel_q      <= RST_BUS_W;
			two_line_sel_q       <= 1'h0;
			ext_reg_enable_q     <= 1'h0;
			user_font_blink_en_q <= 1'h0;
			low_power_sel_q      <= 1'h0;
		end else if (wr_byte && ins[7:5] == 3'h1) begin
			bus_width_sel_q  <= ins[B_DL];
			two_line_sel_q   <= ins[B_N];
			ext_reg_enable_q <= ins[B_RE];
			if (ext_reg_enable_q) begin
				user_font_blink_en_q <= ins[B_BE];
				low_power_sel_q      <= ins[B_LP];
			end
		end else if (wr_byte && ins[7:4] == 4'h1 && !ext_reg_enable_q) begin
			ext_reg_enable_q <= 1'h0;
		end
	end
	// Scroll enable, extended only
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			line_scroll_enable_q <= 4'h0;
		end else if (wr_byte && ins[7:4] == 4'h1 && ext_reg_enable_q) begin
			line_scroll_enable_q <= ins[3:0];
		end
	end
	// Address counter, RAM selection and display shift
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			addr_counter_q       <= RST_AC;
			shift_q              <= 7'h00;
			ram_sel_q            <= RAM_TEXT;
			icon_addr_high_sel_q <= 2'h0;
		end else if (wr_byte) begin
			if (ins[7:2] == 6'h00 && ins[1:0] != 2'h0) begin
				// Clear display and return home
				addr_counter_q <= RST_AC;
				shift_q        <= 7'h00;
				ram_sel_q      <= RAM_TEXT;
			end else if (ins[7:4] == 4'h1 && !ext_reg_enable_q) begin
				if (!ins[B_SHIFT_TGT]) begin
					addr_counter_q <= next_addr(addr_counter_q, ins[B_SHIFT_DIR],
						lines_d);
				end else if (!lp_active) begin
					if (ins[B_SHIFT_DIR]) begin
						shift_q <= (shift_q + 7'h01 >= line_len(lines_d)) ?
							7'h00 : 7'(shift_q + 7'h01);
					end else begin
						shift_q <= (shift_q == 7'h00) ?
							7'(line_len(lines_d) - 7'h01) : 7'(shift_q - 7'h01);
					end
				end
			end else if (ins[7:6] == 2'h1 && !ext_reg_enable_q) begin
				addr_counter_q <= {1'h0, ins[5:0]};
				ram_sel_q      <= RAM_GLYPH;
			end else if (ins[7:6] == 2'h1) begin
				addr_counter_q       <= {3'h0, ins[3:0]};
				icon_addr_high_sel_q <= ins[5:4];
				ram_sel_q            <= RAM_ICON;
			end else if (ins[7] && !ext_reg_enable_q) begin
				addr_counter_q <= ins[6:0];
				ram_sel_q      <= RAM_TEXT;
			end
		end
	end
	// Read data one cycle after the strobe; nibble reads give the high half first
	assign rd_full = (ADDR == ADDR_INSTR) ? {1'h0, addr_counter_q} :
		{ext_reg_enable_q, low_power_sel_q, user_font_blink_en_q, four_line_sel_q,
		two_line_sel_q, invert_cursor_q, font_width_sel_q, bus_width_sel_q};
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rdata_q <= 8'h00;
		end else if (!RD) begin
			rdata_q <= 8'h00;
		end else if (bus_width_sel_q) begin
			rdata_q <= rd_full;
		end else if (rd_byte) begin
			rdata_q <= {rd_full[3:0], 4'h0};
		end else begin
			rdata_q <= {rd_full[7:4], 4'h0};
		end
	end
	// Oscillator tick from the 25 MHz clock
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			osc_cnt_q <= 7'h00;
		end else if (osc_cnt_q == 7'(OSC_DIV - 1)) begin
			osc_cnt_q <= 7'h00;
		end else begin
			osc_cnt_q <= 7'(osc_cnt_q + 7'h01);
		end
	end
	assign osc_tick = osc_cnt_q == 7'(OSC_DIV - 1);
	// Core tick: oscillator, divided in low power mode
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			div_cnt_q   <= 2'h0;
			core_tick_q <= 1'h0;
		end else begin
			core_tick_q <= 1'h0;
			if (osc_tick) begin
				if (!lp_active) begin
					div_cnt_q   <= 2'h0;
					core_tick_q <= 1'h1;
				end else if (div_cnt_q >= 2'((lines_d == LINES_ONE ?
					LP_DIV_ONE : LP_DIV_MULTI) - 1)) begin
					div_cnt_q   <= 2'h0;
					core_tick_q <= 1'h1;
				end else begin
					div_cnt_q <= 2'(div_cnt_q + 2'h1);
				end
			end
		end
	end
	// Blink phase: toggles every blink period of oscillator ticks
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			blink_cnt_q   <= 17'h00000;
			blink_phase_q <= 1'h0;
		end else if (osc_tick) begin
			if (blink_cnt_q >= 17'(BLINK_TICKS - 1)) begin
				blink_cnt_q   <= 17'h00000;
				blink_phase_q <= !blink_phase_q;
			end else begin
				blink_cnt_q <= 17'(blink_cnt_q + 17'h00001);
			end
		end
	end
	// Frame tick: six units instead of five lowers rate to 5/6
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			frame_cnt_q  <= 9'h000;
			frame_tick_q <= 1'h0;
		end else begin
			frame_tick_q <= 1'h0;
			if (osc_tick) begin
				if (frame_cnt_q >= 9'(FRAME_UNIT * ((font_width_sel_q || lp_active) ?
					DOTS_WIDE : DOTS_NARROW) - 1)) begin
					frame_cnt_q  <= 9'h000;
					frame_tick_q <= 1'h1;
				end else begin
					frame_cnt_q <= 9'(frame_cnt_q + 9'h001);
				end
			end
		end
	end
	// Registered display attributes
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			CURSOR_SHOW      <= 1'h0;
			CURSOR_BLANK     <= 1'h0;
			CURSOR_INVERT    <= 1'h0;
			USER_BLINK_PHASE <= 1'h0;
			CELL_DOTS        <= 3'(DOTS_NARROW);
			ROM_LEFT_BLANK   <= 1'h0;
			LINE_MODE        <= LINES_ONE;
			LOW_POWER_ACTIVE <= 1'h0;
		end else begin
			CURSOR_SHOW      <= cursor_q && !invert_cursor_q;
			CURSOR_BLANK     <= char_blink_q && blink_phase_q &&
				!invert_cursor_q;
			CURSOR_INVERT    <= invert_cursor_q && blink_phase_q;
			USER_BLINK_PHASE <= user_font_blink_en_q && blink_phase_q;
			CELL_DOTS        <= 3'(font_width_sel_q ? DOTS_WIDE : DOTS_NARROW);
			ROM_LEFT_BLANK   <= font_width_sel_q;
			LINE_MODE        <= lines_d;
			LOW_POWER_ACTIVE <= lp_active;
		end
	end
	assign RDATA              = rdata_q;
	assign DISPLAY_ON         = disp_on_q;
	assign FRAME_TICK         = frame_tick_q;
	assign CORE_TICK          = core_tick_q;
	assign ADDR_COUNTER       = addr_counter_q;
	assign SHIFT_OFFSET       = shift_q;
	assign LINE_SCROLL_EN     = line_scroll_enable_q;
	assign RAM_SEL            = ram_sel_q;
	assign ICON_ADDR_HIGH_SEL = icon_addr_high_sel_q;
	assign BUS_WIDTH_SEL      = bus_width_sel_q;
	assign EXT_REG_ENABLE     = ext_reg_enable_q;
endmodule : lcdmc_top

// ===== src/lcdmc_pkg.sv
// Purpose: Shared constants for the display mode control block.
// Assumes: Core clock CLOCK at 25 MHz; display oscillator 270 kHz.
// Notes:   Instruction codes are matched on the leading one bit.
package lcdmc_pkg;
	localparam int CLK_KHZ       = 25000;
	localparam int OSC_KHZ       = 270;
	localparam int OSC_DIV       = CLK_KHZ / OSC_KHZ;
	localparam int BLINK_MS      = 370;
	localparam int BLINK_OSC     = BLINK_MS * OSC_KHZ;
	localparam int FRAME_UNIT    = 64;
	localparam int DOTS_NARROW   = 5;
	localparam int DOTS_WIDE     = 6;
	localparam int LP_DIV_ONE    = 4;
	localparam int LP_DIV_MULTI  = 2;

	// Port addresses (the instruction select line)
	localparam logic ADDR_INSTR   = 1'h0;
	localparam logic ADDR_STATUS  = 1'h1;

	// Instruction fields
	localparam int B_SHIFT_TGT   = 3;
	localparam int B_SHIFT_DIR   = 2;
	localparam int B_DL          = 4;
	localparam int B_N           = 3;
	localparam int B_RE          = 2;
	localparam int B_BE          = 1;
	localparam int B_LP          = 0;
	localparam int B_FW          = 2;
	localparam int B_BW          = 1;
	localparam int B_NW          = 0;

	// Address counter limits per line format
	localparam logic [6:0] AC_ONE_LAST  = 7'h4F;
	localparam logic [6:0] AC_TWO_END1  = 7'h27;
	localparam logic [6:0] AC_TWO_BEG2  = 7'h40;
	localparam logic [6:0] AC_TWO_END2  = 7'h67;
	localparam logic [4:0] AC_FOUR_END  = 5'h13;
	localparam logic [6:0] LEN_ONE      = 7'h50;
	localparam logic [6:0] LEN_TWO      = 7'h28;
	localparam logic [6:0] LEN_FOUR     = 7'h14;

	// Reset values
	localparam logic       RST_BUS_W    = 1'h1;
	localparam logic [6:0] RST_AC       = 7'h00;

	typedef enum logic [1:0] {
		LINES_ONE,
		LINES_TWO,
		LINES_FOUR
	} lcdmc_lines_t;

	typedef enum logic [1:0] {
		RAM_TEXT,
		RAM_GLYPH,
		RAM_ICON
	} lcdmc_ram_t;

	typedef enum logic {
		NIB_HIGH,
		NIB_LOW
	} lcdmc_nib_t;
endpackage : lcdmc_pkg

// ===== bench/lcdmc_top_props.sv
// Purpose: Port-level assertions for the display mode control block.
// Assumes: Decode checks only look at full-byte writes (eight-bit bus mode).
// Notes:   Attached to lcdmc_top by the bind after the module.
module lcdmc_top_props (
	input wire logic			CLOCK,
	input wire logic			RST,
	input wire logic			ADDR,
	input wire logic [7:0]			WDATA,
	input wire logic			WR,
	input wire logic			CURSOR_SHOW,
	input wire logic			CURSOR_BLANK,
	input wire logic			CURSOR_INVERT,
	input wire logic [2:0]			CELL_DOTS,
	input wire logic			ROM_LEFT_BLANK,
	input wire lcdmc_pkg::lcdmc_lines_t	LINE_MODE,
	input wire logic [6:0]			ADDR_COUNTER,
	input wire logic [3:0]			LINE_SCROLL_EN,
	input wire logic [1:0]			ICON_ADDR_HIGH_SEL,
	input wire logic			BUS_WIDTH_SEL,
	input wire logic			EXT_REG_ENABLE
);
	timeunit 1ns;
	timeprecision 1ns;
	import lcdmc_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	logic i8;
	assign i8 = WR && !ADDR && BUS_WIDTH_SEL;
	sequence s_cmd(logic re, logic [7:0] m, logic [7:0] v);
		i8 && (EXT_REG_ENABLE == re) && ((WDATA & m) == v);
	endsequence
	AST_SHIFT_CLR_RE: assert property (s_cmd(1'h0, 8'hF0, 8'h10) |=> !EXT_REG_ENABLE)
		else $error("shift left extension enable set");
	AST_DSHIFT_KEEP_AC: assert property (s_cmd(1'h0, 8'hF8, 8'h18) |=> $stable(ADDR_COUNTER))
		else $error("display shift moved address counter");
	AST_CSHIFT_RIGHT: assert property (s_cmd(1'h0, 8'hFC, 8'h14) ##0
		(LINE_MODE == LINES_ONE && ADDR_COUNTER < AC_ONE_LAST)
		|=> ADDR_COUNTER == $past(ADDR_COUNTER) + 7'h01) else $error("cursor right not +1");
	AST_SCROLL_LOAD: assert property (s_cmd(1'h1, 8'hF0, 8'h10)
		|=> LINE_SCROLL_EN == $past(WDATA[3:0])) else $error("scroll enable not loaded");
	AST_SCROLL_HOLD: assert property ($changed(LINE_SCROLL_EN)
		|-> $past(WR && EXT_REG_ENABLE)) else $error("scroll enable changed without extension");
	AST_GLYPH_ADDR: assert property (s_cmd(1'h0, 8'hC0, 8'h40)
		|=> ADDR_COUNTER == {1'h0, $past(WDATA[5:0])}) else $error("glyph address wrong");
	AST_ICON_ADDR: assert property (s_cmd(1'h1, 8'hC0, 8'h40)
		|=> ADDR_COUNTER == {3'h0, $past(WDATA[3:0])} && ICON_ADDR_HIGH_SEL == $past(WDATA[5:4]))
		else $error("icon address wrong");
	AST_BUS_WIDTH: assert property (i8 && (WDATA[7:5] == 3'h1)
		|=> BUS_WIDTH_SEL == $past(WDATA[4])) else $error("bus width not taken");
	AST_FONT_DOTS: assert property (CELL_DOTS == (ROM_LEFT_BLANK ? 3'h6 : 3'h5))
		else $error("cell width and rom blank disagree");
	AST_INVERT_WINS: assert property (CURSOR_INVERT |-> !CURSOR_SHOW && !CURSOR_BLANK)
		else $error("cursor shown during inversion");
	AST_FONT_HOLD: assert property ($changed(CELL_DOTS) |-> $past(WR && EXT_REG_ENABLE, 2))
		else $error("cell width changed without extension write");
endmodule : lcdmc_top_props

bind lcdmc_top lcdmc_top_props u_props (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .CURSOR_SHOW(CURSOR_SHOW), .CURSOR_BLANK(CURSOR_BLANK),
	.CURSOR_INVERT(CURSOR_INVERT), .CELL_DOTS(CELL_DOTS), .ROM_LEFT_BLANK(ROM_LEFT_BLANK),
	.LINE_MODE(LINE_MODE), .ADDR_COUNTER(ADDR_COUNTER), .LINE_SCROLL_EN(LINE_SCROLL_EN),
	.ICON_ADDR_HIGH_SEL(ICON_ADDR_HIGH_SEL), .BUS_WIDTH_SEL(BUS_WIDTH_SEL),
	.EXT_REG_ENABLE(EXT_REG_ENABLE));

// ===== bench/lcdmc_host.sv
// Purpose: Host processor model issuing instructions and reads.
// Assumes: Starts in eight-bit mode, as the block does after reset.
// Notes:   Unused low lanes carry the inverse nibble to catch misuse.
module lcdmc_host (
	input  wire logic	CLOCK,
	input  wire logic [7:0]	RDATA,
	output logic		ADDR,
	output logic [7:0]	WDATA,
	output logic		WR,
	output logic		RD
);
	timeunit 1ns;
	timeprecision 1ns;
	logic nib4 = 1'h0;
	initial begin
		ADDR = 1'h0;
		WDATA = 8'h00;
		WR = 1'h0;
		RD = 1'h0;
	end
	task automatic stroke(input logic w, input logic a, input logic [7:0] d, output logic [7:0] q);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= w;
		RD <= !w;
		@(posedge CLOCK);
		WR <= 1'h0;
		RD <= 1'h0;
		WDATA <= ~d;
		#1 q = RDATA;
	endtask : stroke
	task automatic put(input logic [7:0] d);
		logic [7:0] q;
		if (nib4) begin
			stroke(1'h1, 1'h0, {d[7:4], ~d[7:4]}, q);
			stroke(1'h1, 1'h0, {d[3:0], ~d[3:0]}, q);
		end else begin
			stroke(1'h1, 1'h0, d, q);
		end
		if (d[7:5] == 3'h1) begin
			nib4 = !d[4];
		end
	endtask : put
	task automatic get(input logic a, output logic [7:0] d);
		logic [7:0] h;
		logic [7:0] l;
		stroke(1'h0, a, 8'h00, h);
		if (nib4) begin
			stroke(1'h0, a, 8'h00, l);
			d = {h[7:4], l[7:4]};
		end else begin
			d = h;
		end
	endtask : get
endmodule : lcdmc_host

// ===== bench/lcdmc_bench.sv
// Purpose: Self-checking bench for the display mode control block.
// Assumes: Blink count shortened to a few oscillator ticks.
// Notes:   Periods are counted in core clocks between output toggles.
module lcdmc_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import lcdmc_pkg::*;
	localparam int BT = 4;
	localparam int LIM = 3000;
	logic		CLOCK = 1'h0;
	logic		RST = 1'h1;
	logic		EXPANDER_PRESENT = 1'h0;
	logic		ADDR, WR, RD, ROM_LEFT_BLANK, CORE_TICK, BUS_WIDTH_SEL;
	logic [7:0]	WDATA, RDATA;
	logic		CURSOR_SHOW, CURSOR_BLANK, CURSOR_INVERT, EXT_REG_ENABLE, LOW_POWER_ACTIVE;
	logic		DISPLAY_ON, USER_BLINK_PHASE, FRAME_TICK;
	logic [2:0]	CELL_DOTS;
	logic [6:0]	ADDR_COUNTER, SHIFT_OFFSET;
	logic [3:0]	LINE_SCROLL_EN;
	logic [1:0]	ICON_ADDR_HIGH_SEL;
	lcdmc_lines_t	LINE_MODE;
	lcdmc_ram_t	RAM_SEL;
	int		err_total = 0;
	int		checks = 0;
	int		sel = 0;
	logic		tick_t = 1'h0;
	logic		frame_t = 1'h0;
	logic		w;
	always #20 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		if (CORE_TICK === 1'h1) begin
			tick_t <= ~tick_t;
		end
		if (FRAME_TICK === 1'h1) begin
			frame_t <= ~frame_t;
		end
	end
	assign w = (sel == 0) ? CURSOR_INVERT : (sel == 1) ? CURSOR_BLANK : (sel == 2) ? tick_t :
		(sel == 3) ? USER_BLINK_PHASE : frame_t;
	lcdmc_host u_host (.CLOCK(CLOCK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
	lcdmc_top #(.BLINK_TICKS(BT)) u_dut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .EXPANDER_PRESENT(EXPANDER_PRESENT),
		.DISPLAY_ON(DISPLAY_ON), .USER_BLINK_PHASE(USER_BLINK_PHASE), .FRAME_TICK(FRAME_TICK),
		.CURSOR_SHOW(CURSOR_SHOW), .CURSOR_BLANK(CURSOR_BLANK), .CURSOR_INVERT(CURSOR_INVERT),
		.CELL_DOTS(CELL_DOTS), .ROM_LEFT_BLANK(ROM_LEFT_BLANK),
		.CORE_TICK(CORE_TICK), .LINE_MODE(LINE_MODE),
		.ADDR_COUNTER(ADDR_COUNTER), .SHIFT_OFFSET(SHIFT_OFFSET),
		.LINE_SCROLL_EN(LINE_SCROLL_EN), .RAM_SEL(RAM_SEL),
		.ICON_ADDR_HIGH_SEL(ICON_ADDR_HIGH_SEL), .BUS_WIDTH_SEL(BUS_WIDTH_SEL),
		.EXT_REG_ENABLE(EXT_REG_ENABLE), .LOW_POWER_ACTIVE(LOW_POWER_ACTIVE));
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	// Instruction write, then wait until attribute outputs have followed
	task automatic wr(input logic [7:0] d);
		u_host.put(d);
		repeat (2) @(posedge CLOCK);
		#1;
	endtask : wr
	// Counts clocks between two successive changes of the selected output
	task automatic gap(input int s, input int want);
		logic v;
		int n;
		sel = s;
		for (int k = 0; k < 2; k++) begin
			#1 v = w;
			n = 0;
			while (w === v && n < want + LIM) begin
				@(posedge CLOCK);
				#1 n++;
			end
			if (n >= want + LIM) begin
				err_total++;
				final_report();
			end
		end
		chk("period", n[15:0], want[15:0]);
	endtask : gap
	initial begin
		logic [7:0] d;
		repeat (5) @(posedge CLOCK);
		RST <= 1'h0;
		@(posedge CLOCK);
		#1;
		chk("bus_width", BUS_WIDTH_SEL, 1'h1);
		wr(8'h30);
		chk("lines", LINE_MODE, LINES_ONE);
		wr(8'h38);
		chk("lines", LINE_MODE, LINES_TWO);
		wr(8'h3C);
		wr(8'h0D);
		chk("disp_on", DISPLAY_ON, 1'h0);
		chk("lines", LINE_MODE, LINES_FOUR);
		chk("dots", CELL_DOTS, 3'h6);
		chk("rom_blank", ROM_LEFT_BLANK, 1'h1);
		wr(8'h30);
		wr(8'h08);
		chk("lines", LINE_MODE, LINES_FOUR);
		chk("dots", CELL_DOTS, 3'h6);
		wr(8'h02);
		$display("test formats done");
		wr(8'h93);
		wr(8'h14);
		chk("ac", ADDR_COUNTER, 7'h20);
		wr(8'h14);
		wr(8'h10);
		chk("ac", ADDR_COUNTER, 7'h20);
		wr(8'h3C);
		wr(8'h0C);
		wr(8'h38);
		wr(8'hA7);
		wr(8'h14);
		chk("ac", ADDR_COUNTER, 7'h40);
		wr(8'h1C);
		chk("ac", ADDR_COUNTER, 7'h40);
		chk("shifted", SHIFT_OFFSET == 7'h00, 1'h0);
		wr(8'h18);
		chk("shift", SHIFT_OFFSET, 7'h00);
		u_host.get(1'h0, d);
		chk("ac_read", d, 8'h40);
		$display("test shift done");
		wr(8'h3C);
		wr(8'h13);
		chk("scroll", LINE_SCROLL_EN, 4'h3);
		wr(8'h7A);
		chk("ac", ADDR_COUNTER, 7'h0A);
		chk("icon_hi", ICON_ADDR_HIGH_SEL, 2'h3);
		chk("ram", RAM_SEL, RAM_ICON);
		wr(8'h38);
		wr(8'h15);
		chk("scroll", LINE_SCROLL_EN, 4'h3);
		wr(8'h5F);
		chk("ac", ADDR_COUNTER, 7'h1F);
		chk("ram", RAM_SEL, RAM_GLYPH);
		wr(8'h3B);
		chk("low_power", LOW_POWER_ACTIVE, 1'h0);
		wr(8'h3C);
		wr(8'h3F);
		chk("low_power", LOW_POWER_ACTIVE, 1'h1);
		$display("test extended done");
		gap(2, LP_DIV_MULTI * OSC_DIV);
		wr(8'h37);
		gap(2, LP_DIV_ONE * OSC_DIV);
		wr(8'h33);
		wr(8'h02);
		wr(8'h14);
		chk("ac", ADDR_COUNTER, 7'h01);
		wr(8'h1C);
		chk("shift", SHIFT_OFFSET, 7'h00);
		@(posedge CLOCK);
		EXPANDER_PRESENT <= 1'h1;
		for (int k = 0; k < 10 && LOW_POWER_ACTIVE !== 1'h0; k++) begin
			@(posedge CLOCK);
			#1;
		end
		chk("low_power", LOW_POWER_ACTIVE, 1'h0);
		gap(2, OSC_DIV);
		$display("test low power done");
		wr(8'h0D);
		chk("disp_on", DISPLAY_ON, 1'h1);
		gap(1, BT * OSC_DIV);
		wr(8'h0F);
		chk("cursor", CURSOR_SHOW, 1'h1);
		wr(8'h3C);
		wr(8'h0E);
		chk("cursor", CURSOR_SHOW, 1'h0);
		gap(0, BT * OSC_DIV);
		gap(3, BT * OSC_DIV);
		u_host.get(1'h1, d);
		chk("status", d, 8'hEF);
		gap(4, FRAME_UNIT * DOTS_WIDE * OSC_DIV);
		$display("test blink done");
		wr(8'h38);
		wr(8'h28);
		chk("bus_width", BUS_WIDTH_SEL, 1'h0);
		wr(8'h85);
		chk("ac", ADDR_COUNTER, 7'h05);
		u_host.get(1'h0, d);
		chk("ac_read", d, 8'h05);
		wr(8'h38);
		chk("bus_width", BUS_WIDTH_SEL, 1'h1);
		$display("test nibble done");
		final_report();
	end
endmodule : lcdmc_bench
